// ===== src/ssw_pkg.sv
package ssw_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned T_RST_US = 200_000;
	localparam int unsigned T_WDU_OPEN_US = 1_600_000;
	localparam int unsigned T_WDL_OPEN_US = 800_000;
	localparam int unsigned T_WDU_RES_NS = 11_000_000;
	localparam int unsigned T_WDL_RES_NS = 1_850_000;
	localparam int unsigned T_SETUP_US = 150;
	localparam int unsigned RST_CYC = T_RST_US * CLK_MHZ;
	localparam int unsigned WDU_OPEN_CYC = T_WDU_OPEN_US * CLK_MHZ;
	localparam int unsigned WDL_OPEN_CYC = T_WDL_OPEN_US * CLK_MHZ;
	localparam int unsigned WDU_RES_CYC = (T_WDU_RES_NS / 1000) * CLK_MHZ;
	localparam int unsigned WDL_RES_CYC = (T_WDL_RES_NS * CLK_MHZ + 999) / 1000;
	localparam logic [31:0] SETUP_CYC = 32'(T_SETUP_US * CLK_MHZ);

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;
	localparam int unsigned ST_EARLY = 0;
	localparam int unsigned ST_LATE = 1;
	localparam int unsigned ST_RESET = 2;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	// ************************************************************
	// encodings and carriers
	// ************************************************************
	localparam logic [1:0] SEL_OPEN = 2'h0;
	localparam logic [1:0] SEL_RES = 2'h1;
	localparam logic [1:0] SEL_CAP = 2'h2;

	typedef enum logic [1:0] {
		RS_HOLD = 2'b00,
		RS_COUNT = 2'b01,
		RS_RUN = 2'b10
	} ssw_rst_st_t;

	typedef enum logic [1:0] {
		WD_OFF = 2'b00,
		WD_SETUP = 2'b01,
		WD_WIN = 2'b10,
		WD_FAULT = 2'b11
	} ssw_wd_st_t;

	typedef struct packed {
		logic manual_reset_n;
		logic watchdog_kick_in;
		logic watchdog_enable_strap;
		logic supply_below_threshold;
		logic supply_above_hysteresis;
		logic [1:0] timeout_select_pin;
		logic cap_charged;
	} ssw_pins_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ssw_bus_t;
endpackage

// ===== src/ssw_supervisor_window_watchdog.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
// Function
// R1: manual reset low asserts the reset output.
// R2: after manual reset releases, reset stays asserted for the hold time.
// R3: supply below undervoltage threshold asserts reset.
// R4: supply back in range starts a timeout count; release at completion.
// R5: reset held until supply above threshold plus hysteresis and count done.
// R6: enable strap low disables the watchdog entirely.
// R7: host kicks with a falling edge inside the window, else fault.
// R8: kicks ignored during reset, during fault and while disabled.
// R9: fault output asserts on early kick or missing kick.
// R10: fault only while reset released; reset asserting releases fault.
// R11: fault stays asserted for the reset hold time, then releases.
// R12: open or resistor select pin picks preset window timings.
// R13: capacitor select derives upper bound from measured charge time.
// R14: reset hold time is nominally 200 ms.
// R15: manual reset disables the watchdog and ignores kicks.
// R16: preset upper bounds 1600 ms open and 11.0 ms resistor.
// R17: host allows 150 us setup after enable before kicks count.
// R18: accepted kick restarts window; fault release starts a fresh window.
// R19: watchdog timeout never asserts reset by itself.
module ssw_supervisor_window_watchdog #(
	parameter int unsigned RST_CYC_P = ssw_pkg::RST_CYC,
	parameter int unsigned WDU_OPEN_P = ssw_pkg::WDU_OPEN_CYC,
	parameter int unsigned WDL_OPEN_P = ssw_pkg::WDL_OPEN_CYC,
	parameter int unsigned WDU_RES_P = ssw_pkg::WDU_RES_CYC,
	parameter int unsigned WDL_RES_P = ssw_pkg::WDL_RES_CYC
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire ssw_pkg::ssw_pins_t pins_i,
	input wire ssw_pkg::ssw_bus_t bus_i,
	output logic [31:0] rdata_o,
	output logic reset_out_o,
	output logic reset_oe_o,
	output logic fault_out_o,
	output logic fault_oe_o,
	output logic irq_o
);
	import ssw_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	ssw_rst_st_t rs_q, rs_d;
	ssw_wd_st_t wd_q, wd_d;
	logic [31:0] rst_cnt_q, rst_cnt_d;
	logic [31:0] wd_cnt_q, wd_cnt_d;
	logic [31:0] cap_cnt_q, cap_cnt_d;
	logic [2:0] status_q, status_d;
	logic [2:0] mask_q;
	logic [31:0] rdata_q;
	logic reset_oe_q, reset_oe_d;
	logic fault_oe_q, fault_oe_d;
	logic irq_q;
	logic kick_q;
	logic zero_q;
	wire rst_cnt_done = (rst_cnt_q == RST_CYC_P - 1);
	wire force_reset = !pins_i.manual_reset_n || pins_i.supply_below_threshold;
	wire rst_asserted_d = (rs_d != RS_RUN);
	wire wd_allowed = pins_i.watchdog_enable_strap && pins_i.manual_reset_n && !rst_asserted_d;
	wire kick_fall = kick_q && !pins_i.watchdog_kick_in;
	wire sel_cap = (pins_i.timeout_select_pin == SEL_CAP);
	// R12: R13: R16: window bound selection
	wire [31:0] upper_b = sel_cap ? cap_cnt_q :
		(pins_i.timeout_select_pin == SEL_RES) ? 32'(WDU_RES_P) : 32'(WDU_OPEN_P);
	wire [31:0] lower_b = sel_cap ? {1'b0, cap_cnt_q[31:1]} :
		(pins_i.timeout_select_pin == SEL_RES) ? 32'(WDL_RES_P) : 32'(WDL_OPEN_P);
	wire kick_early = (wd_q == WD_WIN) && kick_fall && (wd_cnt_q < lower_b);
	wire kick_ok = (wd_q == WD_WIN) && kick_fall && (wd_cnt_q >= lower_b);
	wire kick_late = (wd_q == WD_WIN) && !kick_fall && (wd_cnt_q >= upper_b - 1);
	wire wr_status = bus_i.wr && (bus_i.addr == ADDR_STATUS);
	wire wr_mask = bus_i.wr && (bus_i.addr == ADDR_MASK);
	wire [2:0] status_set = {reset_oe_d && !reset_oe_q, kick_late, kick_early};
	wire [2:0] status_clr = wr_status ? bus_i.wdata[2:0] : 3'h0;
	wire [31:0] state_word = {24'h0, wd_q, rs_q, 2'h0, fault_oe_q, reset_oe_q};
	wire [31:0] rdata_d = !bus_i.rd ? 32'h0 :
		(bus_i.addr == ADDR_STATUS) ? {29'h0, status_q} :
		(bus_i.addr == ADDR_MASK) ? {29'h0, mask_q} :
		(bus_i.addr == ADDR_STATE) ? state_word : 32'h0;

	// ************************************************************
	// supervisor reset sequencer
	// ************************************************************
	always_comb begin
		rs_d = rs_q;
		rst_cnt_d = rst_cnt_q;
		case (rs_q)
			RS_HOLD: begin
				rst_cnt_d = 32'h0;
				// R5: wait for hysteresis level
				if (pins_i.manual_reset_n && pins_i.supply_above_hysteresis) begin
					rs_d = RS_COUNT;
				end
			end
			RS_COUNT: begin
				// R2: R4: R14: hold-time count
				if (rst_cnt_done) begin
					rs_d = RS_RUN;
				end else begin
					rst_cnt_d = rst_cnt_q + 32'h1;
				end
			end
			RS_RUN: rst_cnt_d = 32'h0;
			default: rs_d = RS_HOLD;
		endcase
		// R1: R3: R19: only supply and manual reset
		if (force_reset) begin
			rs_d = RS_HOLD;
			rst_cnt_d = 32'h0;
		end
	end

	// ************************************************************
	// window watchdog
	// ************************************************************
	always_comb begin
		wd_d = wd_q;
		wd_cnt_d = wd_cnt_q + 32'h1;
		cap_cnt_d = cap_cnt_q;
		case (wd_q)
			WD_OFF: begin
				wd_cnt_d = 32'h0;
				cap_cnt_d = 32'h0;
				wd_d = WD_SETUP;
			end
			WD_SETUP: begin
				// R13: measure capacitor charge time
				if (sel_cap && !pins_i.cap_charged) begin
					cap_cnt_d = cap_cnt_q + 32'h1;
				end
				if (wd_cnt_q >= SETUP_CYC - 1 && (!sel_cap || pins_i.cap_charged)) begin
					wd_d = WD_WIN;
					wd_cnt_d = 32'h0;
				end
			end
			WD_WIN: begin
				// R9: early or missing kick
				if (kick_early || kick_late) begin
					wd_d = WD_FAULT;
					wd_cnt_d = 32'h0;
				// R18: accepted kick restarts window
				end else if (kick_ok) begin
					wd_cnt_d = 32'h0;
				end
			end
			WD_FAULT: begin
				// R11: R18: fault for hold time, then new window
				if (wd_cnt_q == RST_CYC_P - 1) begin
					wd_d = WD_WIN;
					wd_cnt_d = 32'h0;
				end
			end
			default: wd_d = WD_OFF;
		endcase
		// R6: R8: R15: disabled watchdog ignores kicks
		if (!wd_allowed) begin
			wd_d = WD_OFF;
			wd_cnt_d = 32'h0;
		end
	end

	assign reset_oe_d = rst_asserted_d;
	// R10: fault only while reset released
	assign fault_oe_d = (wd_d == WD_FAULT) && !rst_asserted_d;
	// set wins over a clear in the same cycle
	assign status_d = (status_q & ~status_clr) | status_set;

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rs_q <= RS_HOLD;
			wd_q <= WD_OFF;
			rst_cnt_q <= 32'h0;
			wd_cnt_q <= 32'h0;
			cap_cnt_q <= 32'h0;
			reset_oe_q <= 1'b1;
			fault_oe_q <= 1'b0;
			kick_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			wd_q <= wd_d;
			rst_cnt_q <= rst_cnt_d;
			wd_cnt_q <= wd_cnt_d;
			cap_cnt_q <= cap_cnt_d;
			reset_oe_q <= reset_oe_d;
			fault_oe_q <= fault_oe_d;
			kick_q <= pins_i.watchdog_kick_in;
			zero_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_q <= STATUS_RST;
			mask_q <= MASK_RST;
			rdata_q <= 32'h0;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= bus_i.wdata[2:0];
			end
			rdata_q <= rdata_d;
			irq_q <= |(status_d & mask_q);
		end
	end

	assign rdata_o = rdata_q;
	assign reset_out_o = zero_q;
	assign reset_oe_o = reset_oe_q;
	assign fault_out_o = zero_q;
	assign fault_oe_o = fault_oe_q;
	assign irq_o = irq_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	a_manual_reset_asserts: assert property ( // R1
		!pins_i.manual_reset_n |=> reset_oe_o) else $error("manual reset did not assert reset");
	a_undervolt_asserts: assert property ( // R3
		pins_i.supply_below_threshold |=> reset_oe_o && rs_q == RS_HOLD)
		else $error("undervoltage did not assert reset");
	a_release_after_hold: assert property ( // R2
		$fell(reset_oe_o) |-> $past(rs_q) == RS_COUNT && $past(rst_cnt_q) == RST_CYC_P - 1)
		else $error("reset released before hold time");
	a_hyst_gate: assert property ( // R5
		rs_q == RS_HOLD && !pins_i.supply_above_hysteresis |=> rs_q == RS_HOLD)
		else $error("count began below hysteresis");
	a_strap_disables: assert property ( // R6
		!pins_i.watchdog_enable_strap |=> wd_q == WD_OFF && !fault_oe_o)
		else $error("strap low did not disable watchdog");
	a_early_kick_fault: assert property ( // R9
		kick_early && wd_allowed |=> fault_oe_o ##1 fault_oe_o)
		else $error("early kick gave no fault");
	a_fault_needs_run: assert property ( // R10
		fault_oe_o |-> !reset_oe_o) else $error("fault asserted during reset");
	a_fault_hold_len: assert property ( // R11
		$fell(fault_oe_o) && $past(wd_allowed) |-> $past(wd_cnt_q) == RST_CYC_P - 1)
		else $error("fault released at wrong time");
	a_kick_restart: assert property ( // R18
		kick_ok && wd_allowed |=> wd_cnt_q == 32'h0 && wd_q == WD_WIN)
		else $error("accepted kick did not restart window");
	a_mr_blocks_wd: assert property ( // R15
		!pins_i.manual_reset_n |=> wd_q == WD_OFF) else $error("watchdog ran during manual reset");
	a_fault_no_reset: assert property ( // R19
		rs_q == RS_RUN && !force_reset |=> !reset_oe_o) else $error("watchdog caused reset");
	a_irq_follows: assert property (
		irq_o == |($past(status_d) & $past(mask_q))) else $error("irq mismatch");

	// ************************************************************
	// window bounds and bus checks
	// ************************************************************
	a_open_upper: assert property ( // R12
		wd_q == WD_WIN && wd_allowed && !kick_fall && pins_i.timeout_select_pin == SEL_OPEN
			&& wd_cnt_q == WDU_OPEN_P - 1 |=> fault_oe_o) else $error("open upper bound missed");
	a_res_upper: assert property ( // R16
		wd_q == WD_WIN && wd_allowed && !kick_fall && pins_i.timeout_select_pin == SEL_RES
			&& wd_cnt_q == WDU_RES_P - 1 |=> fault_oe_o) else $error("resistor bound missed");
	a_cap_upper: assert property ( // R13
		wd_q == WD_WIN && wd_allowed && !kick_fall && sel_cap && cap_cnt_q != 32'h0
			&& wd_cnt_q == cap_cnt_q - 32'h1 |=> fault_oe_o) else $error("capacitor bound missed");
	a_cap_measure: assert property ( // R13
		wd_q == WD_SETUP && wd_allowed && sel_cap && !pins_i.cap_charged
			|=> cap_cnt_q == $past(cap_cnt_q) + 32'h1) else $error("charge time not counted");
	a_fault_kick_ignored: assert property ( // R8
		wd_q == WD_FAULT && wd_allowed && kick_fall && wd_cnt_q != RST_CYC_P - 1
			|=> wd_q == WD_FAULT && wd_cnt_q == $past(wd_cnt_q) + 32'h1)
		else $error("kick taken during fault");
	a_hold_counting: assert property ( // R14
		rs_q == RS_COUNT && !force_reset && !rst_cnt_done |=> rs_q == RS_COUNT && reset_oe_o)
		else $error("reset released during hold count");
	a_late_fault: assert property ( // R9
		kick_late && wd_allowed |=> fault_oe_o && status_q[ST_LATE])
		else $error("missing kick gave no fault");
	a_strap_clears_cnt: assert property ( // R6
		!pins_i.watchdog_enable_strap |=> wd_cnt_q == 32'h0) else $error("window count kept");
	a_fault_new_window: assert property ( // R18
		$fell(fault_oe_o) && $past(wd_allowed) |-> wd_q == WD_WIN && wd_cnt_q == 32'h0)
		else $error("no fresh window after fault");
	a_w1c_clear: assert property (
		wr_status && bus_i.wdata[ST_LATE] && !status_set[ST_LATE] |=> !status_q[ST_LATE])
		else $error("status bit not cleared");
	a_rdata_idle: assert property (
		!bus_i.rd |=> rdata_o == 32'h0) else $error("read data without read");
	a_state_read: assert property (
		bus_i.rd && bus_i.addr == ADDR_STATE
			|=> rdata_o[0] == $past(reset_oe_o) && rdata_o[1] == $past(fault_oe_o))
		else $error("state word mismatch");

	c_reset_release: cover property ($fell(reset_oe_o));
	c_early_fault: cover property (kick_early ##1 fault_oe_o);
	c_late_fault: cover property (kick_late ##1 fault_oe_o);
	c_good_kick: cover property (kick_ok);
	c_cap_late: cover property (sel_cap && kick_late);
endmodule // ssw_supervisor_window_watchdog

// ===== tb/ssw_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// host that kicks the watchdog
// ************************************************************
module ssw_host_model (
	input wire logic clk_sys_i,
	input wire logic run_i,
	input wire logic [15:0] period_i,
	output logic kick_o
);
	logic [15:0] cnt_q;
	always_ff @(posedge clk_sys_i) begin
		if (!run_i) begin
			cnt_q <= 16'h0000;
			kick_o <= 1'b1;
		end else if (cnt_q == period_i - 16'h0001) begin
			cnt_q <= 16'h0000;
			kick_o <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			kick_o <= 1'b1;
		end
	end
endmodule // ssw_host_model

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
	import ssw_pkg::*;
	// ************************************************************
	// harness
	// ************************************************************
	localparam int RST = 50;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic run = 1'b0;
	ssw_pins_t p;
	ssw_pins_t pw;
	ssw_bus_t b;
	logic [31:0] rdata;
	logic ro, roe, fo, foe, irq, kick;
	int n_mismatch = 0;
	int checks = 0;
	// open-drain pins with pull-ups
	wire rst_n = roe ? ro : 1'b1;
	wire flt_n = foe ? fo : 1'b1;
	always_comb begin
		pw = p;
		pw.watchdog_kick_in = p.watchdog_kick_in & (kick !== 1'b0);
	end
	ssw_supervisor_window_watchdog #(.RST_CYC_P(RST), .WDU_OPEN_P(400), .WDL_OPEN_P(100),
		.WDU_RES_P(200), .WDL_RES_P(40)) u_ssw_supervisor_window_watchdog (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins_i(pw), .bus_i(b),
		.rdata_o(rdata), .reset_out_o(ro), .reset_oe_o(roe), .fault_out_o(fo),
		.fault_oe_o(foe), .irq_o(irq));
	ssw_host_model u_ssw_host_model (.clk_sys_i(clk_sys_i), .run_i(run),
		.period_i(16'h00FA), .kick_o(kick));
	initial forever #25 clk_sys_i = ~clk_sys_i;
	initial begin
		#3_000_000;
		n_mismatch++;
		summarize();
	end
	// ************************************************************
	// helpers
	// ************************************************************
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rng(input int n, input int lo, input int hi);
		chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		b.addr <= a;
		b.rd <= 1'b1;
		@(posedge clk_sys_i);
		b.rd <= 1'b0;
		@(posedge clk_sys_i);
		d = rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		b.addr <= a;
		b.wdata <= d;
		b.wr <= 1'b1;
		@(posedge clk_sys_i);
		b.wr <= 1'b0;
	endtask
	task automatic dur(input bit f, input logic lvl, input int lim, output int n);
		n = 0;
		while (((f ? flt_n : rst_n) === lvl) && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic cfg(input logic [1:0] sel);
		logic [31:0] d;
		run <= 1'b0;
		p.watchdog_enable_strap <= 1'b0;
		p.cap_charged <= 1'b0;
		cyc(2);
		p.timeout_select_pin <= sel;
		p.watchdog_enable_strap <= 1'b1;
		cyc(300);
		p.cap_charged <= 1'b1;
		d = '0;
		for (int i = 0; i < 2000 && d[7:6] !== 2'h2; i++) rd(ADDR_STATE, d);
		chk(d[7:6], 2'h2);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic s_manual();
		int n;
		logic [31:0] d;
		p.manual_reset_n <= 1'b0;
		cyc(3);
		chk(rst_n, 1'b0);
		rd(ADDR_STATE, d);
		chk(d[7:6], 2'h0);
		rd(ADDR_STATUS, d);
		chk(d[2], 1'b1);
		p.manual_reset_n <= 1'b1;
		dur(0, 0, 500, n);
		rng(n, RST, RST + 4);
	endtask
	task automatic s_uv();
		int n;
		p.supply_below_threshold <= 1'b1;
		p.supply_above_hysteresis <= 1'b0;
		cyc(3);
		chk(rst_n, 1'b0);
		p.supply_below_threshold <= 1'b0;
		cyc(RST + 20);
		chk(rst_n, 1'b0);
		p.supply_above_hysteresis <= 1'b1;
		dur(0, 0, 500, n);
		rng(n, RST, RST + 4);
	endtask
	task automatic s_kick();
		int n;
		logic [31:0] d;
		cfg(SEL_OPEN);
		run <= 1'b1;
		dur(1, 1, 1500, n);
		chk(32'(n), 32'd1500);
		run <= 1'b0;
		dur(1, 1, 600, n);
		rng(n, 396, 404);
		dur(1, 0, 200, n);
		rng(n, RST - 1, RST + 2);
		chk(rst_n, 1'b1);
		rd(ADDR_STATUS, d);
		chk(d[1], 1'b1);
		wr(ADDR_MASK, 32'h0000_0002);
		cyc(3);
		chk(irq, 1'b1);
		wr(ADDR_STATUS, 32'h0000_0002);
		cyc(3);
		chk(irq, 1'b0);
		wr(ADDR_MASK, 32'h0000_0000);
		rd(8'h0C, d);
		chk(d, 32'h0000_0000);
	endtask
	task automatic s_early();
		int n;
		logic [31:0] d;
		cfg(SEL_OPEN);
		p.watchdog_kick_in <= 1'b0;
		cyc(1);
		p.watchdog_kick_in <= 1'b1;
		cyc(5);
		chk(flt_n, 1'b0);
		rd(ADDR_STATUS, d);
		chk(d[0], 1'b1);
		p.watchdog_kick_in <= 1'b0;
		cyc(1);
		p.watchdog_kick_in <= 1'b1;
		dur(1, 0, 200, n);
		rng(n, RST - 14, RST - 4);
	endtask
	task automatic s_nokick(input logic [1:0] sel, input int up);
		int n;
		cfg(sel);
		dur(1, 1, 1000, n);
		rng(n, up - 6, up + 3);
	endtask
	task automatic s_flt_rst();
		int n;
		p.manual_reset_n <= 1'b0;
		cyc(3);
		chk(flt_n, 1'b1);
		p.manual_reset_n <= 1'b1;
		dur(0, 0, 500, n);
		rng(n, RST, RST + 4);
	endtask
	task automatic s_off();
		int n;
		logic [31:0] d;
		p.watchdog_enable_strap <= 1'b0;
		rd(ADDR_STATE, d);
		chk(d[7:6], 2'h0);
		dur(1, 1, 3600, n);
		chk(32'(n), 32'd3600);
	endtask
	initial begin
		int n;
		p = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0};
		b = '0;
		repeat (16) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		dur(0, 0, 500, n);
		rng(n, RST, RST + 4);
		s_manual();
		s_uv();
		s_kick();
		s_early();
		s_nokick(SEL_RES, 200);
		s_flt_rst();
		s_nokick(SEL_CAP, 300);
		s_nokick(SEL_OPEN, 400);
		s_off();
		summarize();
	end
endmodule // tb
